// *** mtl_defs.vh ***
// Constants of the mission temperature logger back end.
// Assumes plain inclusion by its bare name; holds definitions only.
`ifndef MTL_DEFS_VH
`define MTL_DEFS_VH

// Register page, read-only result registers
`define MTL_ADDR_START_MIN   13'h0215
`define MTL_ADDR_START_HOUR  13'h0216
`define MTL_ADDR_START_DATE  13'h0217
`define MTL_ADDR_START_MONTH 13'h0218
`define MTL_ADDR_START_YEAR  13'h0219
`define MTL_ADDR_RUN_LOW     13'h021A
`define MTL_ADDR_RUN_CENTER  13'h021B
`define MTL_ADDR_RUN_HIGH    13'h021C
`define MTL_ADDR_LIFE_LOW    13'h021D
`define MTL_ADDR_LIFE_CENTER 13'h021E
`define MTL_ADDR_LIFE_HIGH   13'h021F

// Alarm timestamp and duration area, low entries first, then high
`define MTL_ALARM_BASE       13'h0220
`define MTL_ALARM_LAST       13'h027F
`define MTL_ALARM_PER_SIDE   4'hC

// Histogram area, 63 bins of two bytes
`define MTL_HIST_BASE        13'h0800
`define MTL_HIST_LAST        13'h087D
`define MTL_HIST_BINS        63
`define MTL_HIST_MAX         16'hFFFF

// Sequential data log, 2048 bytes
`define MTL_LOG_BASE         13'h1000
`define MTL_LOG_LAST         13'h17FF
`define MTL_LOG_DEPTH        2048

// Clamp limits of a reading
`define MTL_TEMP_MIN         8'h00
`define MTL_TEMP_MAX         8'hFA

// Alarm duration limit
`define MTL_DUR_MAX          8'hFF

// Reserved-bit masks of the start time fields
`define MTL_MASK_MIN         8'h7F
`define MTL_MASK_HOUR        8'h7F
`define MTL_MASK_DATE        8'h3F
`define MTL_MASK_MONTH       8'h1F
`define MTL_MASK_YEAR        8'hFF

// Reset value of the lifetime count at power-up
`define MTL_LIFE_RESET       24'h000000

`endif

// *** mtl_logger.v ***
// Mission logging back end: start time, sample counts, data log,
// histogram and temperature alarm recorder, with a byte read port.
// Assumes a minute-boundary tick from the real-time clock, a converter
// that answers each sample request with one reading, and a mission flag
// and configuration bits kept by the surrounding register page.
`timescale 1ns/1ns
`include "mtl_defs.vh"

module mtl_logger #(
    parameter LOG_DEPTH = `MTL_LOG_DEPTH,   // Bytes of the data log
    parameter HIST_BINS = `MTL_HIST_BINS    // Histogram bins
) (
    input  wire        clk_in,              // 50 MHz system clock
    input  wire        rstn_in,             // Synchronous reset, low
    input  wire        minute_tick_in,      // One pulse per minute edge
    input  wire        mission_active_flag_in, // Mission in progress
    input  wire [7:0]  sample_rate_in,      // Minutes between samples
    input  wire        log_wrap_enable_in,  // Data log may wrap
    input  wire        mem_clear_in,        // Clear-memory pulse
    input  wire        conv_valid_in,       // Reading available pulse
    input  wire [7:0]  temp_in,             // Reading, half degrees
    input  wire [7:0]  thresh_low_in,       // Low threshold code
    input  wire [7:0]  thresh_high_in,      // High threshold code
    input  wire        high_flag_clear_in,  // Clear high alarm flag
    input  wire        low_flag_clear_in,   // Clear low alarm flag
    input  wire [7:0]  rtc_minutes_in,      // BCD minutes
    input  wire [7:0]  rtc_hours_in,        // BCD hours with 12/24 bit
    input  wire [7:0]  rtc_date_in,         // BCD date
    input  wire [7:0]  rtc_month_in,        // BCD month
    input  wire [7:0]  rtc_year_in,         // BCD year
    input  wire        rd_en_in,            // Read strobe
    input  wire [12:0] rd_addr_in,          // Byte address
    output reg  [7:0]  rd_data_out,         // Read data, next cycle
    output reg         rd_valid_out,        // Read data valid pulse
    output reg         sample_req_out,      // Conversion request pulse
    output reg         high_alarm_flag_out, // Sticky high alarm
    output reg         low_alarm_flag_out   // Sticky low alarm
);

    // Memories; the data log is not cleared by memory clear
    reg [7:0]  log_mem [0:LOG_DEPTH-1];     // Sequential readings
    reg [15:0] hist_mem [0:HIST_BINS-1];    // Histogram counters
    reg [23:0] alarm_ts [0:23];             // Alarm timestamps
    reg [7:0]  alarm_dur [0:23];            // Alarm durations

    // Result registers
    reg [7:0]  start_min_q;                 // Start minutes
    reg [7:0]  start_hour_q;                // Start hours
    reg [7:0]  start_date_q;                // Start date
    reg [7:0]  start_month_q;               // Start month
    reg [7:0]  start_year_q;                // Start year
    reg [23:0] run_count_q;                 // Mission sample count
    reg [23:0] life_count_q;                // Lifetime sample count

    // Scheduler state
    reg        started_q;                   // First sample requested
    reg        wait_q;                      // Request outstanding
    reg [7:0]  min_cnt_q;                   // Minutes since last sample

    // Alarm recorder state, index 0 low side, 1 high side
    reg [3:0]  al_idx_q [0:1];              // Entries used per side
    reg        al_on_q [0:1];               // Side currently alarming

    // Datapath terms
    wire [7:0]  temp_c;                     // Clamped reading
    wire        take_c;                     // Mission reading accepted
    wire [23:0] run_next_c;                 // Count after this sample
    wire        log_ok_c;                   // Reading goes to the log
    wire [10:0] log_addr_c;                 // Log write slot
    wire [1:0]  hit_c;                      // {high, low} out of band
    reg  [7:0]  rd_byte_c;                  // Read mux result
    integer     i;                          // Clear loop index
    integer     s;                          // Alarm side index
    integer     j;                          // Alarm clear loop index

    // Clamp a raw code into the measurable range
    function [7:0] clamp_code;
        input [7:0] t;
        begin
            if (t > `MTL_TEMP_MAX)
                clamp_code = `MTL_TEMP_MAX;
            else
                clamp_code = t;
        end
    endfunction

    // Saturating bin increment
    function [15:0] sat_inc;
        input [15:0] v;
        begin
            if (v == `MTL_HIST_MAX)
                sat_inc = v;
            else
                sat_inc = v + 16'h0001;
        end
    endfunction

    // Flat alarm entry index from side and per-side slot
    function [4:0] alarm_ent;
        input       side;
        input [3:0] slot;
        begin
            alarm_ent = side ? ({1'b0, slot} + 5'h0C) : {1'b0, slot};
        end
    endfunction

    // Pick one byte of a 24-bit count
    function [7:0] count_byte;
        input [23:0] v;
        input [1:0]  sel;
        begin
            case (sel)
                2'h0:    count_byte = v[7:0];
                2'h1:    count_byte = v[15:8];
                2'h2:    count_byte = v[23:16];
                default: count_byte = 8'h00;
            endcase
        end
    endfunction

    // Out-of-range codes are locked before logging and binning
    assign temp_c = clamp_code(temp_in);
    // Only a reading that answers our own request counts as mission
    assign take_c = conv_valid_in & wait_q & mission_active_flag_in;
    assign run_next_c = run_count_q + 24'h000001;
    // Log slot is the pre-increment count, wrapped modulo the depth
    assign log_addr_c = run_count_q[10:0];
    assign log_ok_c = log_wrap_enable_in |
                      (run_count_q < LOG_DEPTH);
    // Reaching a threshold counts as leaving the band
    assign hit_c = {(temp_c >= thresh_high_in),
                    (temp_c <= thresh_low_in)};

    // Sample scheduler: first sample on the first minute edge of the
    // mission, then one every sample_rate minutes. A zero rate never
    // samples, since no mission can run with it.
    always @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            started_q      <= 1'b0;
            wait_q         <= 1'b0;
            min_cnt_q      <= 8'h00;
            sample_req_out <= 1'b0;
        end
        else
        begin
            sample_req_out <= 1'b0;
            if (!mission_active_flag_in)
            begin
                // Mission ended: forget schedule and pending request
                started_q <= 1'b0;
                wait_q    <= 1'b0;
                min_cnt_q <= 8'h00;
            end
            else if (minute_tick_in && sample_rate_in != 8'h00)
            begin
                if (!started_q || min_cnt_q == sample_rate_in - 8'h01)
                begin
                    sample_req_out <= 1'b1;
                    wait_q         <= 1'b1;
                    started_q      <= 1'b1;
                    min_cnt_q      <= 8'h00;
                end
                else
                begin
                    min_cnt_q <= min_cnt_q + 8'h01;
                    if (conv_valid_in)
                        wait_q <= 1'b0;
                end
            end
            else if (conv_valid_in)
            begin
                wait_q <= 1'b0;                 // Reading consumed
            end
        end
    end

    // Counters and start time; lifetime count reacts to every
    // conversion and only a power-up reset loads it
    always @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            life_count_q  <= `MTL_LIFE_RESET;
            run_count_q   <= 24'h000000;
            start_min_q   <= 8'h00;
            start_hour_q  <= 8'h00;
            start_date_q  <= 8'h00;
            start_month_q <= 8'h00;
            start_year_q  <= 8'h00;
        end
        else
        begin
            if (conv_valid_in)
                life_count_q <= life_count_q + 24'h000001;
            if (mem_clear_in)
            begin
                // Clear has priority over a same-cycle sample
                run_count_q   <= 24'h000000;
                start_min_q   <= 8'h00;
                start_hour_q  <= 8'h00;
                start_date_q  <= 8'h00;
                start_month_q <= 8'h00;
                start_year_q  <= 8'h00;
            end
            else if (take_c)
            begin
                run_count_q <= run_next_c;
                if (run_count_q == 24'h000000)
                begin
                    // Fields stored as BCD, reserved bits forced to 0
                    start_min_q   <= rtc_minutes_in & `MTL_MASK_MIN;
                    start_hour_q  <= rtc_hours_in & `MTL_MASK_HOUR;
                    start_date_q  <= rtc_date_in & `MTL_MASK_DATE;
                    start_month_q <= rtc_month_in & `MTL_MASK_MONTH;
                    start_year_q  <= rtc_year_in & `MTL_MASK_YEAR;
                end
            end
        end
    end

    // Data log write; memory has no reset and is never cleared
    always @(posedge clk_in)
    begin
        if (take_c && log_ok_c && !mem_clear_in)
            log_mem[log_addr_c] <= temp_c;
    end

    // Histogram: clear walks all bins at once, else one bin updates
    always @(posedge clk_in)
    begin
        if (!rstn_in || mem_clear_in)
        begin
            for (i = 0; i < HIST_BINS; i = i + 1)
                hist_mem[i] <= 16'h0000;
        end
        else if (take_c)
        begin
            // Two low bits dropped: four half-degree codes per bin
            hist_mem[temp_c[7:2]] <= sat_inc(hist_mem[temp_c[7:2]]);
        end
    end

    // Alarm recorder: a new entry opens on the first out-of-band
    // reading or when the running duration is full; all 12 slots of
    // a side used means later events are dropped silently
    always @(posedge clk_in)
    begin
        if (!rstn_in || mem_clear_in)
        begin
            for (j = 0; j < 24; j = j + 1)
            begin
                alarm_ts[j]  <= 24'h000000;
                alarm_dur[j] <= 8'h00;
            end
            for (j = 0; j < 2; j = j + 1)
            begin
                al_idx_q[j] <= 4'h0;
                al_on_q[j]  <= 1'b0;
            end
        end
        else if (take_c)
        begin
            for (s = 0; s < 2; s = s + 1)
            begin
                if (!hit_c[s])
                    al_on_q[s] <= 1'b0;         // Back in band
                else if (!al_on_q[s] ||
                    alarm_dur[alarm_ent(s[0], al_idx_q[s] - 4'h1)]
                        == `MTL_DUR_MAX)
                begin
                    // A full side stays idle, so an older entry never
                    // has its duration stretched by a dropped event
                    if (al_idx_q[s] < `MTL_ALARM_PER_SIDE)
                    begin
                        al_on_q[s] <= 1'b1;
                        alarm_ts[alarm_ent(s[0], al_idx_q[s])]
                            <= run_next_c;
                        alarm_dur[alarm_ent(s[0], al_idx_q[s])] <= 8'h01;
                        al_idx_q[s] <= al_idx_q[s] + 4'h1;
                    end
                end
                else
                begin
                    alarm_dur[alarm_ent(s[0], al_idx_q[s] - 4'h1)] <=
                        alarm_dur[alarm_ent(s[0], al_idx_q[s] - 4'h1)]
                        + 8'h01;
                end
            end
        end
    end

    // Sticky alarm flags; a hit in the clear cycle wins over the clear
    always @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            high_alarm_flag_out <= 1'b0;
            low_alarm_flag_out  <= 1'b0;
        end
        else
        begin
            if (take_c && !mem_clear_in && hit_c[1])
                high_alarm_flag_out <= 1'b1;
            else if (high_flag_clear_in)
                high_alarm_flag_out <= 1'b0;
            if (take_c && !mem_clear_in && hit_c[0])
                low_alarm_flag_out <= 1'b1;
            else if (low_flag_clear_in)
                low_alarm_flag_out <= 1'b0;
        end
    end

    // Read decode; unmapped addresses read zero
    always @*
    begin
        rd_byte_c = 8'h00;
        if (rd_addr_in >= `MTL_LOG_BASE && rd_addr_in <= `MTL_LOG_LAST)
            rd_byte_c = log_mem[rd_addr_in[10:0]];
        else if (rd_addr_in >= `MTL_HIST_BASE &&
                 rd_addr_in <= `MTL_HIST_LAST)
        begin
            // Low byte at the even address
            if (rd_addr_in[0])
                rd_byte_c = hist_mem[rd_addr_in[6:1]][15:8];
            else
                rd_byte_c = hist_mem[rd_addr_in[6:1]][7:0];
        end
        else if (rd_addr_in >= `MTL_ALARM_BASE &&
                 rd_addr_in <= `MTL_ALARM_LAST)
        begin
            if (rd_addr_in[1:0] == 2'h3)
                rd_byte_c = alarm_dur[rd_addr_in[6:2] - 5'h08];
            else
                rd_byte_c = count_byte(alarm_ts[rd_addr_in[6:2] - 5'h08],
                                       rd_addr_in[1:0]);
        end
        else
        begin
            case (rd_addr_in)
                `MTL_ADDR_START_MIN:   rd_byte_c = start_min_q;
                `MTL_ADDR_START_HOUR:  rd_byte_c = start_hour_q;
                `MTL_ADDR_START_DATE:  rd_byte_c = start_date_q;
                `MTL_ADDR_START_MONTH: rd_byte_c = start_month_q;
                `MTL_ADDR_START_YEAR:  rd_byte_c = start_year_q;
                `MTL_ADDR_RUN_LOW:     rd_byte_c = count_byte(run_count_q, 2'h0);
                `MTL_ADDR_RUN_CENTER:  rd_byte_c = count_byte(run_count_q, 2'h1);
                `MTL_ADDR_RUN_HIGH:    rd_byte_c = count_byte(run_count_q, 2'h2);
                `MTL_ADDR_LIFE_LOW:    rd_byte_c = count_byte(life_count_q, 2'h0);
                `MTL_ADDR_LIFE_CENTER: rd_byte_c = count_byte(life_count_q, 2'h1);
                `MTL_ADDR_LIFE_HIGH:   rd_byte_c = count_byte(life_count_q, 2'h2);
                default:               rd_byte_c = 8'h00;
            endcase
        end
    end

    // Registered read answer, one cycle after the strobe
    always @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            rd_data_out  <= 8'h00;
            rd_valid_out <= 1'b0;
        end
        else
        begin
            rd_valid_out <= rd_en_in;
            if (rd_en_in)
                rd_data_out <= rd_byte_c;
        end
    end

endmodule // mtl_logger

// *** mtl_monitor.sv ***
// Checker for the logger: request timing, alarm flags, read turn-around.
// Assumes it is bound to mtl_logger and sees only that module's ports.
`timescale 1ns/1ns
module mtl_monitor (
    input wire       clk_in,
    input wire       rstn_in,
    input wire       minute_tick_in,
    input wire       mission_active_flag_in,
    input wire [7:0] sample_rate_in,
    input wire       mem_clear_in,
    input wire       conv_valid_in,
    input wire [7:0] temp_in,
    input wire [7:0] thresh_low_in,
    input wire [7:0] thresh_high_in,
    input wire       high_flag_clear_in,
    input wire       low_flag_clear_in,
    input wire       rd_en_in,
    input wire       rd_valid_out,
    input wire       sample_req_out,
    input wire       high_alarm_flag_out,
    input wire       low_alarm_flag_out
);
    reg        pend_q;                                    // Request open
    wire [7:0] tc = (temp_in > 8'hFA) ? 8'hFA : temp_in;  // Clamped
    // Only a reading that answers a live request is a mission reading
    wire       hit = conv_valid_in && pend_q && mission_active_flag_in
                     && !mem_clear_in;
    wire       hi  = hit && tc >= thresh_high_in;          // High hit
    wire       lo  = hit && tc <= thresh_low_in;           // Low hit

    // Track the open request; a mission end drops it
    always @(posedge clk_in)
    begin
        if (!rstn_in || !mission_active_flag_in)
            pend_q <= 1'b0;
        else if (sample_req_out)
            pend_q <= 1'b1;
        else if (conv_valid_in)
            pend_q <= 1'b0;
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    chk_req_single: assert property (
        sample_req_out |=> !sample_req_out)
        else $error("sample request longer than one cycle");
    chk_req_cause: assert property (
        sample_req_out |-> $past(minute_tick_in) &&
        $past(mission_active_flag_in) && $past(sample_rate_in) != 8'h00)
        else $error("sample request without a minute tick");
    chk_rate_one: assert property (
        minute_tick_in && mission_active_flag_in && sample_rate_in == 8'h01
        |=> sample_req_out)
        else $error("rate one tick gave no request");
    chk_high_set: assert property (
        hi |=> high_alarm_flag_out)
        else $error("high flag not set on high reading");
    chk_low_set: assert property (
        lo |=> low_alarm_flag_out)
        else $error("low flag not set on low reading");
    chk_high_quiet: assert property (
        !high_alarm_flag_out && !hi |=> !high_alarm_flag_out)
        else $error("high flag rose without a high reading");
    chk_low_quiet: assert property (
        !low_alarm_flag_out && !lo |=> !low_alarm_flag_out)
        else $error("low flag rose without a low reading");
    chk_flag_clear: assert property (
        high_flag_clear_in && low_flag_clear_in && !hi && !lo
        |=> !high_alarm_flag_out && !low_alarm_flag_out)
        else $error("alarm flag survived its clear");
    chk_read_turn: assert property (
        rd_en_in |=> rd_valid_out ##1 (rd_valid_out == $past(rd_en_in)))
        else $error("read answer missing or too long");

    cov_high: cover property (hi);
    cov_low: cover property (lo);
    cov_rate3: cover property (sample_req_out && sample_rate_in == 8'h03);
endmodule // mtl_monitor

bind mtl_logger mtl_monitor u_mon (.*);

// *** mtl_conv_model.sv ***
// Converter model: answers each sample request with one reading.
// Assumes requests are one-cycle pulses with at most one open at a time.
`timescale 1ns/1ns
module mtl_conv_model (
    input  wire       clk_in,
    input  wire       sample_req_in,   // Request pulse from the logger
    input  wire       slow_in,         // Answer after three cycles
    input  wire [7:0] temp_src_in,     // Reading to hand back
    output reg        conv_valid_out,  // One-cycle reading strobe
    output reg  [7:0] temp_out         // Reading, valid with the strobe
);
    integer dly = 0;  // Cycles left before the answer, 0 when idle

    initial
    begin
        conv_valid_out = 1'b0;
        temp_out = 8'h00;
    end

    // Drive off the falling edge so the logger samples settled values
    always @(negedge clk_in)
    begin
        conv_valid_out <= 1'b0;
        temp_out <= ~temp_out;  // Not held between readings
        if (sample_req_in === 1'b1)
            dly = slow_in ? 3 : 1;
        else if (dly == 1)
        begin
            conv_valid_out <= 1'b1;
            temp_out <= temp_src_in;
            dly = 0;
        end
        else if (dly > 1)
            dly = dly - 1;
    end
endmodule // mtl_conv_model

// *** tb_mission_temperature_logger.sv ***
// Self-checking bench for mtl_logger with the converter model beside it.
// Assumes the logger, the converter model and the bound checker compile.
`timescale 1ns/1ns
`define CHK(n, e, g) begin num_checks = num_checks + 1; \
    if ((g) !== (e)) begin errors = errors + 1; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_mission_temperature_logger;
    localparam [71:0] CORN = 72'hFA_FF_00_03_04_30_C0_31_BF; // Edge codes
    reg         clk, rstn, tick, mis, wrap, mclr, hclr, lclr, rd_en, slow;
    reg  [7:0]  rate, tl, th, src;
    reg  [12:0] rd_addr;
    reg  [39:0] rtc, st;        // Clock fields, minutes first
    wire [7:0]  temp, rd_data;
    wire        conv_valid, rd_valid, sreq, hflag, lflag;
    reg  [15:0] hist [0:62];    // Expected bins
    reg  [7:0]  logm [0:2047];  // Expected data log
    reg         hf, lf;         // Expected flags
    reg  [31:0] alm [0:23];     // Expected alarm entries, {dur, ts}
    reg  [3:0]  an [0:1];       // Expected entries used per side
    reg         aon [0:1];      // Expected side alarming
    integer     cnt, life, errors, num_checks, nreq, seed, i;

    mtl_logger u_dut (
        .clk_in(clk),
        .rstn_in(rstn),
        .minute_tick_in(tick),
        .mission_active_flag_in(mis),
        .sample_rate_in(rate),
        .log_wrap_enable_in(wrap),
        .mem_clear_in(mclr),
        .conv_valid_in(conv_valid),
        .temp_in(temp),
        .thresh_low_in(tl),
        .thresh_high_in(th),
        .high_flag_clear_in(hclr),
        .low_flag_clear_in(lclr),
        .rtc_minutes_in(rtc[39:32]),
        .rtc_hours_in(rtc[31:24]),
        .rtc_date_in(rtc[23:16]),
        .rtc_month_in(rtc[15:8]),
        .rtc_year_in(rtc[7:0]),
        .rd_en_in(rd_en),
        .rd_addr_in(rd_addr),
        .rd_data_out(rd_data),
        .rd_valid_out(rd_valid),
        .sample_req_out(sreq),
        .high_alarm_flag_out(hflag),
        .low_alarm_flag_out(lflag)
    );

    mtl_conv_model u_conv (
        .clk_in(clk),
        .sample_req_in(sreq),
        .slow_in(slow),
        .temp_src_in(src),
        .conv_valid_out(conv_valid),
        .temp_out(temp)
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Count requests so the sample rate can be judged
    always @(posedge clk)
        if (sreq === 1'b1)
            nreq = nreq + 1;

    task end_sim;
    begin
        if (errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask

    // One read on the byte port, answer one cycle later
    task rd(input [12:0] a, input [7:0] e);
    begin
        @(negedge clk);
        rd_en = 1'b1;
        rd_addr = a;
        @(negedge clk);
        rd_en = 1'b0;
        `CHK("rd_valid", 1'b1, rd_valid)
        `CHK("rd_data", e, rd_data)
    end
    endtask

    task rd3(input [12:0] a, input [23:0] v);
    begin
        rd(a, v[7:0]);
        rd(a + 13'h0001, v[15:8]);
        rd(a + 13'h0002, v[23:16]);
    end
    endtask

    // Expected effect of one accepted, already clamped reading
    task upd(input [7:0] v);
        integer k, e;
        reg     h;
    begin
        if (cnt == 0)
            st = rtc & 40'h7F7F3F1FFF;
        if (wrap || cnt < 2048)
            logm[cnt % 2048] = v;
        if (hist[v[7:2]] != 16'hFFFF)
            hist[v[7:2]] = hist[v[7:2]] + 16'h0001;
        cnt = cnt + 1;
        life = life + 1;
        hf = hf | (v >= th);
        lf = lf | (v <= tl);
        // Alarm area: new episode or full duration opens an entry
        for (k = 0; k < 2; k = k + 1)
        begin
            h = k ? (v >= th) : (v <= tl);
            e = 12 * k + an[k] - 1;
            if (!h)
                aon[k] = 1'b0;
            else if (!aon[k] || alm[e][31:24] == 8'hFF)
            begin
                if (an[k] < 12)
                begin
                    alm[e + 1] = {8'h01, cnt[23:0]};
                    an[k] = an[k] + 4'h1;
                    aon[k] = 1'b1;
                end
            end
            else
                alm[e][31:24] = alm[e][31:24] + 8'h01;
        end
    end
    endtask

    // Minute tick, then wait a bounded time for the reading
    task samp(input [7:0] t, input need);
        integer k;
        reg     got;
    begin
        src = t;
        @(negedge clk);
        tick = 1'b1;
        @(negedge clk);
        tick = 1'b0;
        got = 1'b0;
        for (k = 0; k < 6 && !got; k = k + 1)
        begin
            @(posedge clk);
            got = (conv_valid === 1'b1);
        end
        if (got)
            upd(t > 8'hFA ? 8'hFA : t);
        @(negedge clk);
        `CHK("high flag", hf, hflag)
        `CHK("low flag", lf, lflag)
        if (need)
            `CHK("conv_valid", 1'b1, got)
        if (need && !got)
            end_sim;
    end
    endtask

    task fclr;
    begin
        @(negedge clk);
        {hclr, lclr} = 2'b11;
        @(negedge clk);
        {hclr, lclr} = 2'b00;
        {hf, lf} = 2'b00;
    end
    endtask

    task memclr;
    begin
        @(negedge clk);
        mclr = 1'b1;
        @(negedge clk);
        mclr = 1'b0;
        zap;
    end
    endtask

    // Expected contents after a memory clear
    task zap;
    begin
        cnt = 0;
        for (i = 0; i < 63; i = i + 1)
        begin
            hist[i] = 16'h0000;
            if (i < 24)
                alm[i] = 32'h0;
            if (i < 2)
                {an[i], aon[i]} = 5'h00;
        end
    end
    endtask

    initial
    begin
        seed = 32'hA463;
        {errors, num_checks, nreq, cnt, life} = 0;
        {rstn, tick, mis, wrap, mclr, hclr, lclr, rd_en, slow, hf, lf} = 0;
        {rate, tl, th, src, rd_addr} = 0;
        rtc = {$random(seed), 8'h59};
        st = 40'h0;
        zap;
        repeat (4) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        rd3(13'h021D, 24'h0);
        // Rate three: only ticks 1, 4 and 7 start a conversion
        th = 8'hFA;
        mis = 1'b1;
        rate = 8'h03;
        for (i = 0; i < 7; i = i + 1)
            samp($random(seed), 1'b0);
        `CHK("requests", 3, nreq)
        for (i = 0; i < 5; i = i + 1)
            rd(13'h0215 + i[12:0], st[39 - 8 * i -: 8]);
        rd3(13'h021A, cnt);
        mis = 1'b0;
        memclr;
        rd3(13'h021A, 24'h0);
        rd3(13'h021D, life);
        // Rate one, no wrap: fill the log past its end
        tl = 8'h30;
        th = 8'hC0;
        fclr;
        mis = 1'b1;
        rate = 8'h01;
        for (i = 0; i < 2052; i = i + 1)
        begin
            slow = $random(seed);
            // Long hot spell early, before random events fill the area
            samp(i < 9 ? CORN[71 - 8 * i -: 8] :
                 i < 273 ? 8'hE0 : $random(seed), 1'b1);
            if (i % 16 == 15)
                fclr;
            if (cnt <= 2048 && (i % 97 == 0 || i > 2040))
                rd(13'h0FFF + cnt[12:0], logm[cnt - 1]);
        end
        rd(13'h1000, 8'hFA);
        rd(13'h17FF, logm[2047]);
        wrap = 1'b1;
        samp(8'h55, 1'b1);
        rd(13'h1004, 8'h55);
        for (i = 0; i < 63; i = i + 1)
        begin
            rd(13'h0800 + 2 * i[12:0], hist[i][7:0]);
            rd(13'h0801 + 2 * i[12:0], hist[i][15:8]);
        end
        rd(13'h087E, 8'h00);
        for (i = 0; i < 24; i = i + 1)
        begin
            rd3(13'h0220 + 4 * i[12:0], alm[i][23:0]);
            rd(13'h0223 + 4 * i[12:0], alm[i][31:24]);
        end
        rd3(13'h021A, cnt);
        rd3(13'h021D, life);
        end_sim;
    end
endmodule // tb_mission_temperature_logger
